// ---- hdl/rpt_timer.sv ----
// What this block does
// - Auto mode starts timer at transmission end.
// - Auto, single frame: first bit stops timer.
// - Auto, multi frame: only stop-now or a zero without reload stops.
// - Manual mode ignores transmit/receive events.
// - Gate select: none, pin a, pin b.
// - Active flag ignores gate pin level.
// - Reload-on-zero restarts from reload value.
// - Otherwise stop at zero, set flag.
// - Divider upper nibble in mode register.
// - Tick rate is clock over divider plus one.
// - Reload value in two bytes, upper 2Ch.
// - Reload copied into counter at start and at zero with reload-on-zero.
// - Count upper byte readable at 2Eh.
// - Count lower byte readable at 2Fh.
//
// The address-and-strobe port was chosen for this implementation.

`include "rpt_defines.svh"

`default_nettype none

module rpt_timer
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       tx_end_pulse,
  input  wire logic       rx_first_bit_pulse,
  input  wire logic       gate_input_pin_a,
  input  wire logic       gate_input_pin_b,
  output logic            timer_active_flag,
  output logic            irq
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic rpt_hit
  (
    input logic [7:0] addr,
    input logic [7:0] offset
  );
    rpt_hit = (addr == offset);
  endfunction

  rpt_pkg::rpt_state_t st_r;
  rpt_pkg::rpt_state_t st_nxt;

  logic        auto_start_on_tx_end;
  logic [1:0]  gate_source_select;
  logic        reload_on_zero;
  logic [3:0]  tick_divider_upper;
  logic [11:0] tick_divider_value;
  logic [15:0] reload_value;
  logic        gate_open;
  logic        wr_ctrl;
  logic        start_evt;
  logic        stop_evt;
  logic        tick;
  logic        zero_evt;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign auto_start_on_tx_end = st_r.mode[`RPT_MODE_AUTO];
  assign gate_source_select   = st_r.mode[`RPT_MODE_GATE_HI:`RPT_MODE_GATE_LO];
  assign reload_on_zero       = st_r.mode[`RPT_MODE_RELOAD];
  assign tick_divider_upper   = st_r.mode[`RPT_MODE_PRESC_HI:`RPT_MODE_PRESC_LO];
  assign tick_divider_value   = {tick_divider_upper, st_r.presc_lo};
  assign reload_value         = {st_r.reload_hi, st_r.reload_lo};

  // The code 11 selects no source, so the count simply freezes there.
  always_comb
  begin
    unique case (gate_source_select)
      `RPT_GATE_NONE:  gate_open = 1'b1;
      `RPT_GATE_PIN_A: gate_open = st_r.sync2[0];
      `RPT_GATE_PIN_B: gate_open = st_r.sync2[1];
      default:         gate_open = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Start and stop events
  // ----------------------------------------------------------------
  assign wr_ctrl = reg_wr && rpt_hit(reg_addr, `RPT_ADDR_CTRL);

  // Protocol events only count in auto mode; software start works in both modes unless a stop comes in the same cycle.
  assign start_evt = (auto_start_on_tx_end && tx_end_pulse)
                  || (wr_ctrl && reg_wdata[`RPT_CTRL_START]);

  // In multi-frame receive the first bit is ignored; only stop-now or a zero without reload halts.
  assign stop_evt = (auto_start_on_tx_end && !st_r.multi
                     && rx_first_bit_pulse)
                 || (wr_ctrl && reg_wdata[`RPT_CTRL_STOP]);

  // ----------------------------------------------------------------
  // Prescaler tick
  // ----------------------------------------------------------------
  // One tick every divider+1 cycles while counting and the gate is open.
  assign tick = (st_r.run == rpt_pkg::RPT_COUNT) && gate_open
             && (st_r.pcnt == 12'h000);

  assign zero_evt = tick && (st_r.count == 16'h0000);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;

    // Pins arrive from outside; two stages before any logic reads them.
    st_nxt.sync1 = {gate_input_pin_b, gate_input_pin_a};
    st_nxt.sync2 = st_r.sync1;

    // Register writes.
    if (reg_wr)
    begin
      if (rpt_hit(reg_addr, `RPT_ADDR_MODE))
      begin
        st_nxt.mode = reg_wdata;
      end
      if (rpt_hit(reg_addr, `RPT_ADDR_PRESC_LO))
      begin
        st_nxt.presc_lo = reg_wdata;
      end
      if (rpt_hit(reg_addr, `RPT_ADDR_RELOAD_HI))
      begin
        st_nxt.reload_hi = reg_wdata;
      end
      if (rpt_hit(reg_addr, `RPT_ADDR_RELOAD_LO))
      begin
        st_nxt.reload_lo = reg_wdata;
      end
      if (rpt_hit(reg_addr, `RPT_ADDR_CTRL))
      begin
        st_nxt.multi = reg_wdata[`RPT_CTRL_MULTI];
      end
      if (rpt_hit(reg_addr, `RPT_ADDR_IRQ_MASK))
      begin
        st_nxt.irq_mask = reg_wdata[`RPT_IRQ_ZERO];
      end
      if (rpt_hit(reg_addr, `RPT_ADDR_IRQ_STAT) && reg_wdata[`RPT_IRQ_ZERO])
      begin
        st_nxt.irq_stat = 1'b0;
      end
    end

    // Counting. The gate stalls the prescaler too, so a closed gate
    // freezes both the count and the phase of the next tick.
    if ((st_r.run == rpt_pkg::RPT_COUNT) && gate_open)
    begin
      if (st_r.pcnt == 12'h000)
      begin
        st_nxt.pcnt = tick_divider_value;
      end
      else
      begin
        st_nxt.pcnt = st_r.pcnt - 12'h001;
      end
    end

    if (tick)
    begin
      if (st_r.count != 16'h0000)
      begin
        st_nxt.count = st_r.count - 16'h0001;
      end
      else if (reload_on_zero)
      begin
        st_nxt.count = reload_value;
      end
      else
      begin
        st_nxt.run = rpt_pkg::RPT_IDLE;
      end
    end

    // A zero event sets the flag even against a clear in the same cycle.
    if (zero_evt)
    begin
      st_nxt.irq_stat = 1'b1;
    end

    // Start reloads the count; elsewhere only a zero with reload-on-zero loads the reload bytes.
    if (start_evt)
    begin
      st_nxt.run   = rpt_pkg::RPT_COUNT;
      st_nxt.count = reload_value;
      st_nxt.pcnt  = tick_divider_value;
    end

    // Stop wins over a start in the same cycle.
    if (stop_evt)
    begin
      st_nxt.run = rpt_pkg::RPT_IDLE;
    end

    // Read data stand only in the cycle after the read strobe.
    st_nxt.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `RPT_ADDR_MODE:      st_nxt.rdata = st_r.mode;
        `RPT_ADDR_PRESC_LO:  st_nxt.rdata = st_r.presc_lo;
        `RPT_ADDR_RELOAD_HI: st_nxt.rdata = st_r.reload_hi;
        `RPT_ADDR_RELOAD_LO: st_nxt.rdata = st_r.reload_lo;
        `RPT_ADDR_COUNT_HI:  st_nxt.rdata = st_r.count[15:8];
        `RPT_ADDR_COUNT_LO:  st_nxt.rdata = st_r.count[7:0];
        `RPT_ADDR_CTRL:      st_nxt.rdata = {5'h00, st_r.multi, 2'b00};
        `RPT_ADDR_STATUS:    st_nxt.rdata = {7'h00, st_r.run};
        `RPT_ADDR_IRQ_STAT:  st_nxt.rdata = {7'h00, st_r.irq_stat};
        `RPT_ADDR_IRQ_MASK:  st_nxt.rdata = {7'h00, st_r.irq_mask};
        default:             st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r.mode      <= `RPT_RST_BYTE;
      st_r.presc_lo  <= `RPT_RST_BYTE;
      st_r.reload_hi <= `RPT_RST_BYTE;
      st_r.reload_lo <= `RPT_RST_BYTE;
      st_r.multi     <= 1'b0;
      st_r.irq_stat  <= 1'b0;
      st_r.irq_mask  <= 1'b0;
      st_r.run       <= rpt_pkg::RPT_IDLE;
      st_r.count     <= `RPT_RST_COUNT;
      st_r.pcnt      <= `RPT_RST_PCNT;
      st_r.rdata     <= `RPT_RST_BYTE;
      st_r.sync1     <= 2'b00;
      st_r.sync2     <= 2'b00;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata         = st_r.rdata;
  assign timer_active_flag = (st_r.run == rpt_pkg::RPT_COUNT);
  assign irq               = st_r.irq_stat && st_r.irq_mask;

endmodule // rpt_timer

`default_nettype wire

// ---- hdl/rpt_defines.svh ----
`ifndef RPT_DEFINES_SVH
`define RPT_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RPT_ADDR_MODE       8'h2a
`define RPT_ADDR_PRESC_LO   8'h2b
`define RPT_ADDR_RELOAD_HI  8'h2c
`define RPT_ADDR_RELOAD_LO  8'h2d
`define RPT_ADDR_COUNT_HI   8'h2e
`define RPT_ADDR_COUNT_LO   8'h2f
`define RPT_ADDR_CTRL       8'h38
`define RPT_ADDR_STATUS     8'h39
`define RPT_ADDR_IRQ_STAT   8'h3a
`define RPT_ADDR_IRQ_MASK   8'h3b

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RPT_MODE_AUTO       7
`define RPT_MODE_GATE_HI    6
`define RPT_MODE_GATE_LO    5
`define RPT_MODE_RELOAD     4
`define RPT_MODE_PRESC_HI   3
`define RPT_MODE_PRESC_LO   0
`define RPT_CTRL_STOP       0
`define RPT_CTRL_START      1
`define RPT_CTRL_MULTI      2
`define RPT_STAT_ACTIVE     0
`define RPT_IRQ_ZERO        0

// ----------------------------------------------------------------
// Gate select codes
// ----------------------------------------------------------------
`define RPT_GATE_NONE       2'b00
`define RPT_GATE_PIN_A      2'b01
`define RPT_GATE_PIN_B      2'b10

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RPT_RST_BYTE        8'h00
`define RPT_RST_COUNT       16'h0000
`define RPT_RST_PCNT        12'h000

`endif

// ---- hdl/rpt_pkg.sv ----
`default_nettype none

package rpt_pkg;

  typedef enum logic [0:0]
  {
    RPT_IDLE  = 1'b0,
    RPT_COUNT = 1'b1
  } rpt_run_t;

  typedef struct packed
  {
    logic [7:0]  mode;
    logic [7:0]  presc_lo;
    logic [7:0]  reload_hi;
    logic [7:0]  reload_lo;
    logic        multi;
    logic        irq_stat;
    logic        irq_mask;
    rpt_run_t    run;
    logic [15:0] count;
    logic [11:0] pcnt;
    logic [7:0]  rdata;
    logic [1:0]  sync1;
    logic [1:0]  sync2;
  } rpt_state_t;

endpackage : rpt_pkg

`default_nettype wire

// ---- verification/rpt_timer_asserts.sv ----
`default_nettype none
module rpt_timer_asserts
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       tx_end_pulse,
  input wire logic       rx_first_bit_pulse,
  input wire logic       gate_input_pin_a,
  input wire logic       gate_input_pin_b,
  input wire logic       timer_active_flag,
  input wire logic       irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mode_r;
  logic       multi_r;
  wire        stop_w = reg_wr && reg_addr == 8'h38 && reg_wdata[0];
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Shadow of the mode bits, so that each check sees the mode that is in force.
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      mode_r  <= 8'h00;
      multi_r <= 1'b0;
    end
    else if (reg_wr && reg_addr == 8'h2a)
      mode_r  <= reg_wdata;
    else if (reg_wr && reg_addr == 8'h38)
      multi_r <= reg_wdata[2];
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("stray read data");
  a_auto_start: assert property (mode_r[7] && tx_end_pulse && !timer_active_flag
    && !rx_first_bit_pulse && !reg_wr |=> timer_active_flag) else $error("no auto start");
  a_first_bit_stop: assert property (mode_r[7] && !multi_r && rx_first_bit_pulse
    |=> !timer_active_flag) else $error("no stop on first bit");
  a_multi_hold: assert property (mode_r[7] && mode_r[4] && multi_r && !reg_wr
    && rx_first_bit_pulse && timer_active_flag |=> timer_active_flag) else $error("stopped");
  a_stop_now: assert property (stop_w |=> !timer_active_flag)
    else $error("stop ignored");
  a_manual_ignore: assert property (!mode_r[7] && !reg_wr && tx_end_pulse
    && !timer_active_flag |=> !timer_active_flag) else $error("manual start");
  a_irq_clear: assert property (reg_wr && reg_addr == 8'h3a && reg_wdata[0]
    && !timer_active_flag |=> !irq) else $error("irq not cleared");
  a_gate_hold: assert property (timer_active_flag && mode_r[6:5] == 2'b01
    && !mode_r[7] && !reg_wr && !gate_input_pin_a && !$past(gate_input_pin_a)
    && !$past(gate_input_pin_a, 2) |=> timer_active_flag) else $error("gated stop");
endmodule // rpt_timer_asserts
bind rpt_timer rpt_timer_asserts i_rpt_timer_asserts (.*);
`default_nettype wire

// ---- verification/rpt_timer_bench.sv ----
`default_nettype none
module rpt_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       tx_end_pulse = 1'b0;
  logic       rx_first_bit_pulse = 1'b0;
  logic       gate_input_pin_a = 1'b0;
  logic       gate_input_pin_b = 1'b0;
  logic [7:0] reg_rdata;
  logic       timer_active_flag;
  logic       irq;
  logic [7:0] exp_q[$];
  logic [7:0] e;
  logic [7:0] d;
  logic       rd_q = 1'b0;
  int         mismatches = 0;
  int         total_checks = 0;
  int         cycles = 0;
  int         seed = 32'h746d;
  int         n0, n1, na, nb;
  rpt_timer i_rpt_timer (.*);
  initial forever #4 clk = ~clk;
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Read data stand for one cycle only, so the oldest note is compared right then.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      mismatches++;
      conclude();
    end
    if (rd_q)
    begin
      e = exp_q.pop_front();
      `CHK(reg_rdata, e)
    end
    rd_q <= reg_rd;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    exp_q.push_back(v);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input logic rx);
    {rx_first_bit_pulse, tx_end_pulse} <= rx ? 2'h2 : 2'h1;
    @(posedge clk);
    {rx_first_bit_pulse, tx_end_pulse} <= 2'h0;
    @(posedge clk);
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (logic [7:0] a = 8'h2a; a < 8'h30; a++)
      rd(a, 8'h00);
    rd(8'h40, 8'h00);
    for (logic [7:0] a = 8'h2a; a < 8'h2e; a++)
    begin
      d = 8'($random(seed));
      wr(a, d);
      rd(a, d);
    end
    wr(8'h2e, 8'h5a);
    rd(8'h2e, 8'h00);
    $display("test registers done");
    wr(8'h3b, 8'h01);
    wr(8'h2c, 8'h00);
    wr(8'h2d, 8'h01);
    wr(8'h2b, 8'h09);
    wr(8'h2a, 8'h10);
    wr(8'h38, 8'h02);
    wait_irq(n0);
    wr(8'h3a, 8'h01);
    wr(8'h2d, 8'h05);
    wait_irq(n1);
    `CHK(n1, 16)
    wr(8'h38, 8'h01);
    rd(8'h39, 8'h00);
    wr(8'h3a, 8'h01);
    wr(8'h38, 8'h02);
    wait_irq(na);
    `CHK(na - n0, 40)
    wr(8'h38, 8'h01);
    wr(8'h3a, 8'h01);
    wr(8'h2a, 8'h01);
    wr(8'h38, 8'h02);
    wait_irq(nb);
    `CHK(nb - na, 1536)
    rd(8'h39, 8'h00);
    wr(8'h3b, 8'h00);
    `CHK(irq, 1'b0)
    rd(8'h3a, 8'h01);
    wr(8'h3a, 8'h01);
    wr(8'h3b, 8'h01);
    `CHK(irq, 1'b0)
    $display("test timing done");
    wr(8'h2a, 8'h90);
    pulse(1'b0);
    rd(8'h39, 8'h01);
    pulse(1'b1);
    rd(8'h39, 8'h00);
    wr(8'h38, 8'h04);
    pulse(1'b0);
    pulse(1'b1);
    rd(8'h39, 8'h01);
    wr(8'h38, 8'h05);
    rd(8'h39, 8'h00);
    wr(8'h2a, 8'h10);
    pulse(1'b0);
    rd(8'h39, 8'h00);
    wr(8'h38, 8'h02);
    pulse(1'b1);
    rd(8'h39, 8'h01);
    $display("test auto done");
    for (logic [1:0] g = 2'h1; g != 2'h0; g++)
    begin
      wr(8'h38, 8'h01);
      wr(8'h3a, 8'h01);
      wr(8'h2a, {1'b0, g, 5'h00});
      wr(8'h38, 8'h02);
      repeat (80) @(posedge clk);
      rd(8'h39, 8'h01);
      rd(8'h2f, 8'h05);
      gate_input_pin_a <= g[0];
      gate_input_pin_b <= g[1];
      repeat (100) @(posedge clk);
      rd(8'h3a, {7'h00, g != 2'h3});
      gate_input_pin_a <= 1'b0;
      gate_input_pin_b <= 1'b0;
    end
    $display("test gating done");
    conclude();
  end
endmodule // rpt_timer_bench
`default_nettype wire
